// ===== bench/dsar_host_model.sv
`default_nettype none
module dsar_host_model (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  input wire logic dout,
  output logic sclk_pin,
  output logic select_shutdown_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Deselected, clock parked low
  initial begin
    sclk_pin = 1'b0;
    select_shutdown_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One frame; each bit taken late in the low phase
  task automatic run(input int falls, output logic [15:0] bits);
    bits = '0;
    select_shutdown_n = 1'b0;
    tick(8);
    for (int i = 0; i < falls; i++) begin
      sclk_pin = 1'b1;
      tick(8);
      sclk_pin = 1'b0;
      tick(8);
      bits = {bits[14:0], dout};
    end
    select_shutdown_n = 1'b1;
    tick(8);
  endtask
endmodule
`default_nettype wire

// ===== bench/dsar_serial_readout_assertions.sv
`default_nettype none
module dsar_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Watched ports
  input wire logic sclk_pin,
  input wire logic select_shutdown_n,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire dsar_pkg::dsar_analog_s analog,
  input wire logic standby,
  input wire dsar_pkg::dsar_result_s result
);
  import dsar_pkg::*;
  logic sclk_ff;
  logic [3:0] age_ff;
  logic [3:0] nxt_age;
  // Cycles since a serial clock fall
  always_comb begin
    nxt_age = (age_ff == 4'hf) ? 4'hf : age_ff + 4'h1;
    if (sclk_ff && !sclk_pin) begin
      nxt_age = 4'h0;
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_ff <= 1'b0;
      age_ff <= 4'hf;
    end else begin
      sclk_ff <= sclk_pin;
      age_ff <= nxt_age;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  a_dout_on_fall: assert property ($changed(dout) |-> age_ff < 4'h8 || $rose(dout_oe_n))
    else $error("dout off edge");
  a_idle_standby: assert property (select_shutdown_n [*8] |-> standby && dout_oe_n)
    else $error("no standby");
  a_abort_quiet: assert property (select_shutdown_n [*8] |-> !result.valid)
    else $error("valid deselected");
  a_sel_drives: assert property (!select_shutdown_n [*8] |-> !dout_oe_n && !standby)
    else $error("not driving");
  a_start_track: assert property ($fell(select_shutdown_n) |-> ##[2:7] analog.track)
    else $error("no tracking");
  a_track_span: assert property ($rose(analog.track) |-> analog.track [*8])
    else $error("short window");
  a_hold_trial: assert property ($fell(analog.track) && !standby |-> analog.dac_code == TRIAL_START)
    else $error("bad first trial");
  a_valid_frame: assert property (result.valid |-> !dout_oe_n && dout == result.code[0])
    else $error("bad valid");
  a_one_valid: assert property (result.valid |=> !result.valid [*8])
    else $error("valid twice");
  c_result: cover property (result.valid);
  c_hold: cover property ($fell(analog.track) && !standby);
  c_abort: cover property ($rose(standby));
endmodule
bind dsar_serial_readout dsar_chk chk (.ref_clk(ref_clk), .arst_n(arst_n), .sclk_pin(sclk_pin),
  .select_shutdown_n(select_shutdown_n), .dout(dout), .dout_oe_n(dout_oe_n), .analog(analog),
  .standby(standby), .result(result));
`default_nettype wire

// ===== bench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dsar_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sclk_pin, select_shutdown_n, cmp_above, dout, dout_oe_n, standby;
  dsar_analog_s analog;
  dsar_result_s result;
  logic [12:0] target = 13'h0000;
  int n_errors = 0;
  int checks = 0;
  int n_valid = 0;
  always #5 ref_clk = ~ref_clk;
  // Result pulses counted while they stand
  always @(posedge ref_clk) begin
    if (result.valid === 1'b1) begin
      n_valid++;
    end
  end
  // Comparator: trial kept while input at or above it
  assign cmp_above = analog.dac_code <= (target ^ TRIAL_START);
  dsar_serial_readout dut (.ref_clk(ref_clk), .arst_n(arst_n), .sclk_pin(sclk_pin),
    .select_shutdown_n(select_shutdown_n), .cmp_above(cmp_above), .dout(dout),
    .dout_oe_n(dout_oe_n), .analog(analog), .standby(standby), .result(result));
  dsar_host_model host (.ref_clk(ref_clk), .dout(dout), .sclk_pin(sclk_pin),
    .select_shutdown_n(select_shutdown_n));
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Boundary codes, one spare clock per frame
  task automatic test_codes();
    logic [12:0] codes [5] = '{13'h1000, 13'h0fff, 13'h0001, 13'h0000, 13'h1ffe};
    logic [15:0] bits;
    int seen;
    foreach (codes[i]) begin
      target = codes[i];
      seen = n_valid;
      host.run(16, bits);
      check("serial", {2'b00, codes[i], 1'b0}, {1'b0, bits[14:0]});
      check("code", {3'h0, codes[i]}, {3'h0, result.code});
      check("sign", {15'h0, codes[i][12]}, {15'h0, bits[13]});
      check("pulses", 16'h1, 16'(n_valid - seen));
      check("idle", 16'h2, {14'h0, standby, analog.track});
    end
    $display("test_codes done");
  endtask
  // Abort mid conversion, then a fresh frame
  task automatic test_abort();
    logic [15:0] bits;
    logic [12:0] prev;
    int seen;
    prev = result.code;
    target = 13'h0555;
    seen = n_valid;
    host.run(8, bits);
    check("kept", {3'h0, prev}, {3'h0, result.code});
    check("oe", 16'h1, {15'h0, dout_oe_n});
    check("lost", 16'h0, 16'(n_valid - seen));
    check("asleep", 16'h2, {14'h0, standby, analog.track});
    seen = n_valid;
    host.run(15, bits);
    check("again", {3'h0, target}, {3'h0, result.code});
    check("pulse again", 16'h1, 16'(n_valid - seen));
    $display("test_abort done");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    check("standby", 16'h1, {15'h0, standby});
    test_codes();
    test_abort();
    close_out();
  end
  // Watchdog
  initial begin
    #100us;
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire

// ===== hdl/dsar_serial_readout.sv
`default_nettype none
module dsar_serial_readout (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Serial pins from host
  input wire logic sclk_pin,
  input wire logic select_shutdown_n,
  // Comparator from analog core, same clock
  input wire logic cmp_above,
  // Serial data out pin
  output logic dout,
  output logic dout_oe_n,
  // Analog core control
  output dsar_pkg::dsar_analog_s analog,
  output logic standby,
  // Parallel result
  output dsar_pkg::dsar_result_s result
);
  import dsar_pkg::*;

  // ************************************************
  // Pin synchronisers
  // ************************************************
  logic [2:0] sclk_sync_ff;
  logic [2:0] sel_sync_ff;
  logic [2:0] nxt_sclk_sync;
  logic [2:0] nxt_sel_sync;
  logic sclk_filt_ff;
  logic sel_n_filt_ff;
  logic nxt_sclk_filt;
  logic nxt_sel_n_filt;

  // Shift chains; level accepted when stages two and three agree
  always_comb begin
    nxt_sclk_sync = {sclk_sync_ff[1:0], sclk_pin};
    nxt_sel_sync = {sel_sync_ff[1:0], select_shutdown_n};
    nxt_sclk_filt = sclk_filt_ff;
    nxt_sel_n_filt = sel_n_filt_ff;
    if (sclk_sync_ff[1] == sclk_sync_ff[2]) begin
      nxt_sclk_filt = sclk_sync_ff[2];
    end
    if (sel_sync_ff[1] == sel_sync_ff[2]) begin
      nxt_sel_n_filt = sel_sync_ff[2];
    end
  end

  // Synchroniser registers; select idles deasserted
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_sync_ff <= 3'h0;
      sel_sync_ff <= 3'h7;
      sclk_filt_ff <= 1'b0;
      sel_n_filt_ff <= 1'b1;
    end else begin
      sclk_sync_ff <= nxt_sclk_sync;
      sel_sync_ff <= nxt_sel_sync;
      sclk_filt_ff <= nxt_sclk_filt;
      sel_n_filt_ff <= nxt_sel_n_filt;
    end
  end

  // Falling serial clock edge, one cycle pulse
  logic sclk_fall;
  assign sclk_fall = sclk_filt_ff & ~nxt_sclk_filt;

  // ************************************************
  // Conversion sequencer
  // ************************************************
  // Sequencer state and position counters
  dsar_state_e state_ff;
  dsar_state_e nxt_state;
  logic [1:0] acq_cnt_ff;
  logic [1:0] nxt_acq_cnt;
  logic [IDX_W-1:0] bit_idx_ff;
  logic [IDX_W-1:0] nxt_bit_idx;

  // SAR trial code and sample switch
  logic [ADC_BITS-1:0] trial_ff;
  logic [ADC_BITS-1:0] nxt_trial;
  logic track_ff;
  logic nxt_track;

  // Finished result
  logic valid_ff;
  logic nxt_valid;
  logic [ADC_BITS-1:0] code_ff;
  logic [ADC_BITS-1:0] nxt_code;

  // Serial pin drive and power state
  logic dout_ff;
  logic nxt_dout;
  logic oe_n_ff;
  logic nxt_oe_n;
  logic standby_ff;
  logic nxt_standby;

  // Offset-binary trial bit weight for a bit position
  function automatic logic [ADC_BITS-1:0] bit_weight(input logic [IDX_W-1:0] idx);
    bit_weight = CODE_FIRST_POS << idx;
  endfunction

  // Fall that closes the sample window
  function automatic logic acq_last(input logic [1:0] cnt);
    acq_last = (cnt == ACQ_FALL_EDGES - 2'h1);
  endfunction

  // Fall that resolves the final bit
  function automatic logic bit_last(input logic [IDX_W-1:0] idx);
    bit_last = (idx == LSB_IDX);
  endfunction

  // Next state and counters
  always_comb begin
    nxt_state = state_ff;
    nxt_acq_cnt = acq_cnt_ff;
    nxt_bit_idx = bit_idx_ff;
    if (sel_n_filt_ff) begin
      // Abandon the frame
      nxt_state = ST_STANDBY;
      nxt_acq_cnt = 2'h0;
    end else begin
      case (state_ff)
        ST_STANDBY: begin
          // Select low opens the sample window
          nxt_state = ST_ACQ;
          nxt_acq_cnt = 2'h0;
        end
        ST_ACQ: begin
          if (sclk_fall) begin
            nxt_acq_cnt = acq_cnt_ff + 2'h1;
            if (acq_last(acq_cnt_ff)) begin
              nxt_state = ST_CONV;
              nxt_bit_idx = MSB_IDX;
            end
          end
        end
        ST_CONV: begin
          if (sclk_fall) begin
            if (bit_last(bit_idx_ff)) begin
              nxt_state = ST_DONE;
            end else begin
              nxt_bit_idx = bit_idx_ff - 4'h1;
            end
          end
        end
        ST_DONE: begin
          // One conversion per select low
          nxt_state = ST_DONE;
        end
        default: begin
          nxt_state = ST_STANDBY;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_STANDBY;
      acq_cnt_ff <= 2'h0;
      bit_idx_ff <= LSB_IDX;
    end else begin
      state_ff <= nxt_state;
      acq_cnt_ff <= nxt_acq_cnt;
      bit_idx_ff <= nxt_bit_idx;
    end
  end

  // Next trial code, sample switch and result
  always_comb begin
    nxt_trial = trial_ff;
    nxt_track = track_ff;
    nxt_valid = 1'b0;
    nxt_code = code_ff;
    if (sel_n_filt_ff) begin
      // Conversion lost, no result
      nxt_track = 1'b0;
      nxt_trial = CODE_ZERO;
    end else begin
      case (state_ff)
        ST_STANDBY: begin
          // Both inputs tracked together
          nxt_track = 1'b1;
        end
        ST_ACQ: begin
          if (sclk_fall && acq_last(acq_cnt_ff)) begin
            // Hold switches open, SAR begins at the sign weight
            nxt_track = 1'b0;
            nxt_trial = TRIAL_START;
          end
        end
        ST_CONV: begin
          if (sclk_fall) begin
            // Keep or drop the trial bit
            nxt_trial = cmp_above ? trial_ff : (trial_ff & ~bit_weight(bit_idx_ff));
            if (bit_last(bit_idx_ff)) begin
              nxt_valid = 1'b1;
              // Offset binary to two's complement by flipping the sign
              nxt_code = nxt_trial ^ CODE_MOST_NEG;
            end else begin
              nxt_trial = nxt_trial | bit_weight(bit_idx_ff - 4'h1);
            end
          end
        end
        ST_DONE: begin
          // Result stands until the next conversion completes
          nxt_code = code_ff;
        end
        default: begin
          nxt_valid = 1'b0;
        end
      endcase
    end
  end

  // SAR and result registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trial_ff <= CODE_ZERO;
      track_ff <= 1'b0;
      valid_ff <= 1'b0;
      code_ff <= CODE_ZERO;
    end else begin
      trial_ff <= nxt_trial;
      track_ff <= nxt_track;
      valid_ff <= nxt_valid;
      code_ff <= nxt_code;
    end
  end

  // Next serial output, enable and power state
  always_comb begin
    nxt_dout = dout_ff;
    nxt_oe_n = oe_n_ff;
    nxt_standby = standby_ff;
    if (sel_n_filt_ff) begin
      // Release pin, low power
      nxt_oe_n = 1'b1;
      nxt_dout = 1'b0;
      nxt_standby = 1'b1;
    end else begin
      case (state_ff)
        ST_STANDBY: begin
          // Wake and drive the pin
          nxt_standby = 1'b0;
          nxt_oe_n = 1'b0;
          nxt_dout = 1'b0;
        end
        ST_ACQ: begin
          if (sclk_fall && acq_last(acq_cnt_ff)) begin
            // Null bit ahead of the sign
            nxt_dout = 1'b0;
          end
        end
        ST_CONV: begin
          if (sclk_fall) begin
            // Each decision leaves at once, sign inverted
            if (bit_idx_ff == MSB_IDX) begin
              nxt_dout = ~cmp_above;
            end else begin
              nxt_dout = cmp_above;
            end
          end
        end
        ST_DONE: begin
          // Extra clocks shift zeros until select rises
          if (sclk_fall) begin
            nxt_dout = 1'b0;
          end
        end
        default: begin
          nxt_dout = 1'b0;
        end
      endcase
    end
  end

  // Pin and power registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      standby_ff <= 1'b1;
    end else begin
      dout_ff <= nxt_dout;
      oe_n_ff <= nxt_oe_n;
      standby_ff <= nxt_standby;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  // All straight from registers
  assign dout = dout_ff;
  assign dout_oe_n = oe_n_ff;
  assign standby = standby_ff;
  assign analog = '{track: track_ff, dac_code: trial_ff};
  assign result = '{valid: valid_ff, code: code_ff};
endmodule
`default_nettype wire

// ===== inc/dsar_pkg.sv
`default_nettype none
package dsar_pkg;
  // ************************************************
  // Widths and codes
  // ************************************************
  localparam int ADC_BITS = 13;
  localparam int IDX_W = 4;
  localparam logic [12:0] CODE_MOST_NEG = 13'h1000;
  localparam logic [12:0] CODE_MOST_POS = 13'h0fff;
  localparam logic [12:0] CODE_FIRST_POS = 13'h0001;
  localparam logic [12:0] CODE_ZERO = 13'h0000;
  localparam logic [12:0] TRIAL_START = 13'h1000;
  localparam logic [3:0] MSB_IDX = 4'hc;
  localparam logic [3:0] LSB_IDX = 4'h0;
  localparam int NUM_CODES = 8192;

  // ************************************************
  // Sequencing counts
  // ************************************************
  // Falling serial clock edges that close the sample window (1.5 cycles)
  localparam logic [1:0] ACQ_FALL_EDGES = 2'h2;
  localparam int MIN_SCLK_KHZ = 85;

  // ************************************************
  // Types
  // ************************************************
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_ACQ = 2'b01,
    ST_CONV = 2'b10,
    ST_DONE = 2'b11
  } dsar_state_e;

  typedef struct packed {
    logic track;
    logic [12:0] dac_code;
  } dsar_analog_s;

  typedef struct packed {
    logic valid;
    logic [12:0] code;
  } dsar_result_s;
endpackage
`default_nettype wire
